/* watch_time_keeper_pkg.sv */
`default_nettype none
package watch_time_keeper_pkg;
   localparam int unsigned CLK_HZ          = 200_000_000;
   localparam int unsigned XTAL_HZ         = 32_768;
   localparam int unsigned SEC_W           = 6;
   localparam int unsigned MIN_W           = 6;
   localparam int unsigned HOUR_W          = 5;
   localparam int unsigned DAY_W           = 15;
   localparam logic [5:0]  SEC_MAX         = 6'h3B;
   localparam logic [5:0]  MIN_MAX         = 6'h3B;
   localparam logic [4:0]  HOUR_MAX        = 5'h17;
   localparam int unsigned SW_W            = 16;
   localparam int unsigned EV_W            = 7;
   localparam int unsigned EV_SEC          = 0;
   localparam int unsigned EV_MIN          = 1;
   localparam int unsigned EV_HOUR         = 2;
   localparam int unsigned EV_DAY          = 3;
   localparam int unsigned EV_ALM_DAILY    = 4;
   localparam int unsigned EV_ALM_DATED    = 5;
   localparam int unsigned EV_SW           = 6;

   typedef struct packed {
      logic [DAY_W-1:0]  day;
      logic [HOUR_W-1:0] hour;
      logic [MIN_W-1:0]  min;
      logic [SEC_W-1:0]  sec;
   } time_type;

   typedef enum logic [1:0] {
      PW_RUN   = 2'b00,
      PW_SLEEP = 2'b01,
      PW_DEEP  = 2'b10,
      PW_HIB   = 2'b11
   } power_state_type;
endpackage
`default_nettype wire

/* wtk_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none
// counts crystal edges, sampled by the core clock, down to one pulse a second
module wtk_prescaler #(
   parameter int unsigned DIV = 32_768
) (
   input  wire logic i_core_clk,   // core clock
   input  wire logic i_rst_b,      // async reset, active low
   input  wire logic i_xtal,       // crystal clock level, treated as synchronous
   output logic      o_tick        // one-cycle pulse per second
);
   localparam int unsigned CW = $clog2(DIV);
   initial begin
      if (DIV < 2) $error("prescaler divide too small");
   end
   logic          xtal_q;
   logic [CW-1:0] cnt_q;
   logic          rise;
   assign rise = i_xtal & ~xtal_q;

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         xtal_q <= 1'b0;
      end else begin
         xtal_q <= i_xtal;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q  <= '0;
         o_tick <= 1'b0;
      end else begin
         o_tick <= 1'b0;
         if (rise) begin
            if (cnt_q == CW'(DIV - 1)) begin
               cnt_q  <= '0;
               o_tick <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* wtk_wake_gate.sv */
`timescale 1ns/10ps
`default_nettype none
// forwards pending events as wake requests according to the power state
module wtk_wake_gate #(
   parameter int unsigned N = 7
) (
   input  wire logic                                   i_core_clk,  // core clock
   input  wire logic                                   i_rst_b,     // async reset
   input  wire logic [N-1:0]                           i_pending,   // sticky flags
   input  wire logic [N-1:0]                           i_wake_en,   // wake enables
   input  wire watch_time_keeper_pkg::power_state_type i_power,     // core power state
   output logic                                        o_wake,      // sleep wake
   output logic                                        o_deep_wake, // deep sleep wake
   output logic                                        o_hib_exit   // hibernate exit
);
   logic any;
   assign any = |(i_pending & i_wake_en);

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_wake      <= 1'b0;
         o_deep_wake <= 1'b0;
         o_hib_exit  <= 1'b0;
      end else begin
         o_wake      <= 1'b0;
         o_deep_wake <= 1'b0;
         o_hib_exit  <= 1'b0;
         case (i_power)
            watch_time_keeper_pkg::PW_SLEEP: o_wake      <= any;
            watch_time_keeper_pkg::PW_DEEP:  o_deep_wake <= any;
            watch_time_keeper_pkg::PW_HIB:   o_hib_exit  <= any;
            default: begin
               o_wake <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* watch_time_keeper.sv */
// Behaviour
// - crystal prescaled to one tick per second
// - seconds, minutes, hours, days counters cascade
// - second, minute, hour, day interrupts selectable
// - enabled alarm interrupts when time matches
// - daily alarm and dated day alarm
// - stopwatch loaded, decrements each second
// - enabled stopwatch interrupts on underflow
// - enabled events wake from ordinary sleep
// - events also wake deep sleep, exit hibernate
// - counting unaffected by core power state
// - wake forwarded only if wake enable set
`timescale 1ns/10ps
`default_nettype none
module watch_time_keeper #(
   parameter int unsigned PRESCALE = 32_768
) (
   input  wire logic                                   i_core_clk,      // always-on clock
   input  wire logic                                   i_rst_b,         // async reset, low
   input  wire logic                                   i_crystal_in_pin, // crystal level
   input  wire logic                                   i_time_load,     // load time pulse
   input  wire watch_time_keeper_pkg::time_type        i_time_value,    // time to load
   input  wire watch_time_keeper_pkg::time_type        i_alarm_value,   // alarm setting
   input  wire logic                                   i_sw_load,       // stopwatch load
   input  wire logic [watch_time_keeper_pkg::SW_W-1:0] i_sw_value,      // stopwatch value
   input  wire logic                                   i_sw_enable,     // stopwatch enable
   input  wire logic [watch_time_keeper_pkg::EV_W-1:0] i_irq_enable,    // per-event enable
   input  wire logic [watch_time_keeper_pkg::EV_W-1:0] i_status_clear,  // write-one clear
   input  wire logic [watch_time_keeper_pkg::EV_W-1:0] i_wakeup_enable_regs, // wake enables
   input  wire watch_time_keeper_pkg::power_state_type i_power_state,   // core power state
   output var watch_time_keeper_pkg::time_type         o_time,          // running time
   output logic [watch_time_keeper_pkg::SW_W-1:0]      o_sw_count,      // stopwatch count
   output logic [watch_time_keeper_pkg::EV_W-1:0]      o_status,        // sticky flags
   output logic                                        o_irq,           // interrupt level
   output logic                                        o_wake,          // sleep wake
   output logic                                        o_deep_wake,     // deep sleep wake
   output logic                                        o_hib_exit       // hibernate exit
);
   initial begin
      if (PRESCALE != watch_time_keeper_pkg::XTAL_HZ) $error("prescale must be one second");
   end

   logic tick;
   logic [watch_time_keeper_pkg::EV_W-1:0] ev;
   logic sec_wrap, min_wrap, hour_wrap, day_wrap;
   logic tod_match;
   logic sw_wrap;

   // no power input reaches these counters, so low power never stops them
   wtk_prescaler #(.DIV(PRESCALE)) u_pre (
      .i_core_clk (i_core_clk),
      .i_rst_b    (i_rst_b),
      .i_xtal     (i_crystal_in_pin),
      .o_tick     (tick)
   );

   assign sec_wrap  = tick && o_time.sec == watch_time_keeper_pkg::SEC_MAX;
   assign min_wrap  = sec_wrap && o_time.min == watch_time_keeper_pkg::MIN_MAX;
   assign hour_wrap = min_wrap && o_time.hour == watch_time_keeper_pkg::HOUR_MAX;
   assign day_wrap  = hour_wrap;

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_time <= '0;
      end else if (i_time_load) begin
         o_time <= i_time_value;
      end else if (tick) begin
         o_time.sec <= sec_wrap ? '0 : o_time.sec + 1'b1;
         if (sec_wrap) begin
            o_time.min <= min_wrap ? '0 : o_time.min + 1'b1;
         end
         if (min_wrap) begin
            o_time.hour <= hour_wrap ? '0 : o_time.hour + 1'b1;
         end
         if (hour_wrap) begin
            o_time.day <= o_time.day + 1'b1;  // natural wrap after 32767
         end
      end
   end

   // compare one cycle after the tick, so the freshly counted time is seen
   logic tick_q;
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= tick;
      end
   end
   assign tod_match = tick_q
                      && o_time.hour == i_alarm_value.hour
                      && o_time.min == i_alarm_value.min
                      && o_time.sec == i_alarm_value.sec;

   assign sw_wrap = tick && i_sw_enable && o_sw_count == '0;

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_sw_count <= '0;
      end else if (i_sw_load) begin
         o_sw_count <= i_sw_value;
      end else if (tick && i_sw_enable) begin
         o_sw_count <= o_sw_count - 1'b1;
      end
   end

   always_comb begin
      ev = '0;
      ev[watch_time_keeper_pkg::EV_SEC]       = tick;
      ev[watch_time_keeper_pkg::EV_MIN]       = sec_wrap;
      ev[watch_time_keeper_pkg::EV_HOUR]      = min_wrap;
      ev[watch_time_keeper_pkg::EV_DAY]       = day_wrap;
      ev[watch_time_keeper_pkg::EV_ALM_DAILY] = tod_match;
      ev[watch_time_keeper_pkg::EV_ALM_DATED] = tod_match
                                                && o_time.day == i_alarm_value.day;
      ev[watch_time_keeper_pkg::EV_SW]        = sw_wrap;
   end

   // only enabled sources latch; a set in the clear cycle wins
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_status <= '0;
      end else begin
         o_status <= (o_status & ~i_status_clear) | (ev & i_irq_enable);
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(o_status & i_irq_enable);
      end
   end

   wtk_wake_gate #(.N(watch_time_keeper_pkg::EV_W)) u_wake (
      .i_core_clk  (i_core_clk),
      .i_rst_b     (i_rst_b),
      .i_pending   (o_status),
      .i_wake_en   (i_wakeup_enable_regs),
      .i_power     (i_power_state),
      .o_wake      (o_wake),
      .o_deep_wake (o_deep_wake),
      .o_hib_exit  (o_hib_exit)
   );
endmodule
`default_nettype wire

/* watch_time_keeper_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module watch_time_keeper_checker (
   input wire logic                                   i_core_clk,           // clock
   input wire logic                                   i_rst_b,              // reset
   input wire logic                                   i_time_load,          // load
   input wire logic                                   i_sw_load,            // load
   input wire logic [6:0]                             i_irq_enable,         // enables
   input wire logic [6:0]                             i_status_clear,       // clears
   input wire logic [6:0]                             i_wakeup_enable_regs, // wake enables
   input wire watch_time_keeper_pkg::power_state_type i_power_state,        // power
   input wire watch_time_keeper_pkg::time_type        o_time,               // time
   input wire logic [15:0]                            o_sw_count,           // stopwatch
   input wire logic [6:0]                             o_status,             // flags
   input wire logic                                   o_irq,                // irq
   input wire logic                                   o_wake,               // wake
   input wire logic                                   o_deep_wake,          // deep wake
   input wire logic                                   o_hib_exit            // hibernate exit
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   sequence s_sec_leave;
      (o_time.sec == watch_time_keeper_pkg::SEC_MAX && !i_time_load) ##1 $changed(o_time.sec);
   endsequence
   sequence s_sw_under;
      (o_sw_count == 16'h0000 && i_irq_enable[6] && !i_sw_load) ##1 (o_sw_count == 16'hFFFF);
   endsequence
   property p_sec_wrap;
      s_sec_leave |-> o_time.sec == 6'h00 && o_time.min == (($past(o_time.min) == 6'h3B) ?
         6'h00 : $past(o_time.min) + 6'h01);
   endproperty
   property p_sw_step;
      !i_sw_load ##1 $changed(o_sw_count) |-> o_sw_count == $past(o_sw_count) - 16'h0001;
   endproperty
   property p_sw_flag;
      s_sw_under |-> o_status[6];
   endproperty
   property p_irq;
      1 |=> o_irq == $past(|(o_status & i_irq_enable));
   endproperty
   property p_sticky;
      1 |=> ($past(o_status) & ~o_status & ~$past(i_status_clear)) == 7'h00;
   endproperty
   property p_gate;
      1 |=> (o_status & ~$past(o_status) & ~$past(i_irq_enable)) == 7'h00;
   endproperty
   property p_wake;
      1 |=> {o_wake, o_deep_wake, o_hib_exit} == ($past(|(o_status & i_wakeup_enable_regs)) ?
         {$past(i_power_state) == 2'b01, $past(i_power_state) == 2'b10,
          $past(i_power_state) == 2'b11} : 3'b000);
   endproperty
   property p_run_quiet;
      i_power_state == watch_time_keeper_pkg::PW_RUN [*2] |-> !o_wake && !o_deep_wake;
   endproperty
   a_sec_wrap: assert property (p_sec_wrap) else $error("seconds wrap wrong");
   a_sw_step: assert property (p_sw_step) else $error("stopwatch step wrong");
   a_sw_flag: assert property (p_sw_flag) else $error("underflow flag missing");
   a_irq: assert property (p_irq) else $error("irq level wrong");
   a_sticky: assert property (p_sticky) else $error("flag dropped uncleared");
   a_gate: assert property (p_gate) else $error("disabled event latched");
   a_wake: assert property (p_wake) else $error("wake outputs wrong");
   a_run_quiet: assert property (p_run_quiet) else $error("wake in run state");
endmodule
bind watch_time_keeper watch_time_keeper_checker watch_time_keeper_checker_inst (
   .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_time_load(i_time_load),
   .i_sw_load(i_sw_load), .i_irq_enable(i_irq_enable), .i_status_clear(i_status_clear),
   .i_wakeup_enable_regs(i_wakeup_enable_regs), .i_power_state(i_power_state),
   .o_time(o_time), .o_sw_count(o_sw_count), .o_status(o_status), .o_irq(o_irq),
   .o_wake(o_wake), .o_deep_wake(o_deep_wake), .o_hib_exit(o_hib_exit));
`default_nettype wire

/* tb_watch_time_keeper.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
   $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end
module tb_watch_time_keeper;
   logic                                   clk = 0, rst_b = 0, xtal = 0, run = 0;
   logic                                   tload = 0, swload = 0, swen = 0;
   logic                                   irq, wk, dwk, hib;
   logic [15:0]                            swval = '0, swcnt;
   logic [6:0]                             irqen = '0, clr = '0, wken = '0, st;
   watch_time_keeper_pkg::time_type        tval = '0, aval = '0, tnow;
   watch_time_keeper_pkg::power_state_type pwr = watch_time_keeper_pkg::PW_RUN;
   int                                     fails = 0, comparisons = 0, cyc = 0, n;
   watch_time_keeper watch_time_keeper_inst (
      .i_core_clk(clk), .i_rst_b(rst_b), .i_crystal_in_pin(xtal), .i_time_load(tload),
      .i_time_value(tval), .i_alarm_value(aval), .i_sw_load(swload), .i_sw_value(swval),
      .i_sw_enable(swen), .i_irq_enable(irqen), .i_status_clear(clr),
      .i_wakeup_enable_regs(wken), .i_power_state(pwr), .o_time(tnow), .o_sw_count(swcnt),
      .o_status(st), .o_irq(irq), .o_wake(wk), .o_deep_wake(dwk), .o_hib_exit(hib));
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (run) xtal <= ~xtal;
      // one tick needs 65536 cycles at the fastest crystal the sampler can see
      if (cyc == 90000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic report_and_stop();
      if (fails == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // every counter at its last value, so one tick wraps all and fires every event
   task automatic t_full_rollover();
      @(posedge clk) begin
         tval <= '{day: 15'h7FFF, hour: 5'h17, min: 6'h3B, sec: 6'h3B};
         tload <= 1'b1;
         swload <= 1'b1;
         irqen <= 7'h7F;
         swen <= 1'b1;
         pwr <= watch_time_keeper_pkg::PW_DEEP;
      end
      @(posedge clk) begin
         tload <= 1'b0;
         swload <= 1'b0;
         run <= 1'b1;
      end
      step(1);
      `CHK(tnow, tval)
      for (n = 0; n < 70000 && tnow === tval; n++) step(1);
      `CHK(n > 65530 && n < 65545, 1'b1)
      `CHK(tnow, 32'h0000_0000)
      `CHK(swcnt, 16'hFFFF)
      `CHK(st[3:0], 4'hF)
      step(2);
      `CHK(st[5:4], 2'h3)
      `CHK(irq, 1'b1)
      `CHK(dwk, 1'b0)
      @(posedge clk) run <= 1'b0;
   endtask
   task automatic t_wake_states();
      @(posedge clk) wken <= 7'h40;
      for (int p = 0; p < 4; p++) begin
         @(posedge clk) pwr <= watch_time_keeper_pkg::power_state_type'(p);
         step(3);
         `CHK({wk, dwk, hib}, (p == 0) ? 3'h0 : 3'h4 >> (p - 1))
      end
   endtask
   task automatic t_mask_clear();
      @(posedge clk) irqen <= 7'h00;
      step(3);
      `CHK(irq, 1'b0)
      `CHK(st, 7'h7F)
      @(posedge clk) clr <= 7'h40;
      @(posedge clk) clr <= 7'h00;
      step(2);
      `CHK(st, 7'h3F)
      `CHK(hib, 1'b0)
   endtask
   initial begin
      step(5);
      `CHK(st, 7'h00)
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      step(2);
      t_full_rollover();
      t_wake_states();
      t_mask_clear();
      report_and_stop();
   end
endmodule
`default_nettype wire
